/* common/pwm_timer_defs.svh */
// register offsets, field positions and reset values of the pwm timer
`ifndef PWM_TIMER_DEFS_SVH
`define PWM_TIMER_DEFS_SVH
`define OFS_MASTER_IRQ  8'hA8
`define OFS_MODE        8'hAB
`define OFS_PERIOD_LO   8'hAC
`define OFS_PERIOD_HI   8'hAD
`define OFS_TRAIL_LO    8'hAE
`define OFS_TRAIL_HI    8'hAF
`define OFS_DUTY_LO     8'hBB
`define OFS_DUTY_HI     8'hBC
`define OFS_LEAD        8'hBD
`define OFS_CHANNEL     8'hBE
`define OFS_IRQ4        8'hD1
`define BIT_ENABLE      7
`define BIT_PRESC_HI    6
`define BIT_PRESC_LO    4
`define BIT_INV2        3
`define BIT_INV1        2
`define BIT_ONE_PULSE   0
`define BIT_GLOBAL_IRQ  7
`define BIT_OVF_IRQ_EN  7
`define BIT_OVF_FLAG    3
`define CHANNEL_MASK    8'h33
`define MODE_MASK       8'hFD
`define IRQ4_MASK       8'h88
`define RESET_BYTE      8'h00
`define PRESC_MAX       7'h7F
`define AXI_OKAY        2'h0
`define AXI_DECERR      2'h3
`endif

/* common/pwm_timer_pkg.sv */
// types shared by the pwm timer
package pwm_timer_pkg;
  typedef struct packed {
    logic [3:0] pinOut;
    logic [3:0] pinSel;
  } pin_drive_t;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_t;
endpackage

/* logic/pwm_timer.sv */
// pwm timer with dead band, axi4-lite register slave
//
// Contract
// - mode bit 7 enables the timer; resets to zero.
// - mode bits 6..4 select divide 128 (000) down to divide 1 (111).
// - mode bit 3 inverts the second pair outputs.
// - mode bit 2 inverts the first pair outputs.
// - mode bit 0 selects one pulse; bit 1 reserved, zero.
// - zero period at enable stops the timer; later period writes ignored.
// - channel bits 5,4,1,0 route pins to pwm; others reserved.
// - sixteen bit period in two bytes, read write, reset zero.
// - sixteen bit duty in two bytes, read write, reset zero.
// - sixteen bit trailing dead band in two bytes, reset zero.
// - eight bit leading dead band register, reset zero.
// - irq4 bit 7 lets the overflow flag request an interrupt.
// - irq4 bit 3 is the overflow flag, cleared by writing zero.
// - master bit 7 gates the pwm interrupt request.
// - setting enable is offered to the adc as a start source.
// - cycle starts high from zero, goes low at duty match.
// - at period match set flag, reload zero, output high.
// - one pulse clears enable after first cycle, pins back to gpio.
// - dead bands cut both ends of the pulse; too long means no pulse.
`timescale 1ns/1ps
`include "pwm_timer_defs.svh"

module pwm_timer (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic [9:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [9:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [3:0]               gpioOut,
  output pwm_timer_pkg::pin_drive_t     pinDrive,
  output logic                          pwmIrq,
  output logic                          adcStart
);
  import pwm_timer_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  modeReg;
  logic [7:0]  channelReg;
  logic [15:0] periodReg;
  logic [15:0] dutyReg;
  logic [15:0] trailReg;
  logic [7:0]  leadReg;
  logic        globalIrqEnReg;
  logic        ovfIrqEnReg;
  logic        ovfFlagReg;
  logic [15:0] countReg;
  logic [6:0]  prescReg;
  logic        stoppedReg;
  logic        enablePrevReg;
  logic        runReg;
  logic [3:0]  pinOutReg;
  logic [3:0]  pinSelReg;

  logic        awHeld;
  logic        wHeld;
  logic [9:0]  awAddrReg;
  logic [31:0] wDataReg;
  logic        wStrbReg;
  wr_state_t   wrState;
  logic        rValidReg;
  logic [31:0] rDataReg;
  logic [1:0]  rRespReg;
  logic [1:0]  bRespReg;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `OFS_MASTER_IRQ) || (a == `OFS_MODE) || (a == `OFS_PERIOD_LO)
            || (a == `OFS_PERIOD_HI) || (a == `OFS_TRAIL_LO) || (a == `OFS_TRAIL_HI)
            || (a == `OFS_DUTY_LO) || (a == `OFS_DUTY_HI) || (a == `OFS_LEAD)
            || (a == `OFS_CHANNEL) || (a == `OFS_IRQ4);
  endfunction

  // printed offsets are not word aligned: byte address is four times the index
  function automatic logic [7:0] regIndex(input logic [9:0] byteAddr);
    regIndex = byteAddr[9:2];
  endfunction

  // ****************************************
  // axi write channel
  // ****************************************
  assign s_axi_awready = !awHeld && (wrState == WR_IDLE);
  assign s_axi_wready  = !wHeld && (wrState == WR_IDLE);
  assign s_axi_bvalid  = (wrState == WR_RESP);
  assign s_axi_bresp   = bRespReg;

  logic       wrFire;
  logic [7:0] wrIdx;
  logic [7:0] wrByte;
  assign wrFire = awHeld && wHeld && (wrState == WR_IDLE);
  assign wrIdx  = regIndex(awAddrReg);
  assign wrByte = wDataReg[7:0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awHeld    <= 1'b0;
      wHeld     <= 1'b0;
      awAddrReg <= 10'h000;
      wDataReg  <= 32'h0000_0000;
      wStrbReg  <= 1'b0;
      wrState   <= WR_IDLE;
      bRespReg  <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld    <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld    <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb[0];
      end
      if (wrFire) begin
        awHeld   <= 1'b0;
        wHeld    <= 1'b0;
        wrState  <= WR_RESP;
        bRespReg <= isMapped(wrIdx) ? `AXI_OKAY : `AXI_DECERR;
      end else if (wrState == WR_RESP && s_axi_bready) begin
        wrState <= WR_IDLE;
      end
    end
  end

  logic wrEn;
  assign wrEn = wrFire && wStrbReg;

  // ****************************************
  // counter side signals
  // ****************************************
  logic        tick;
  logic        periodHit;
  logic        enableRise;
  logic        onePulseEnd;
  logic        runNext;
  assign tick        = (prescReg == 7'h00);
  // counter runs 0 .. period-1, so one cycle lasts exactly period ticks
  assign periodHit   = runReg && tick && (countReg == (periodReg - 16'h0001));
  assign enableRise  = modeReg[`BIT_ENABLE] && !enablePrevReg;
  assign onePulseEnd = periodHit && modeReg[`BIT_ONE_PULSE];
  assign runNext     = modeReg[`BIT_ENABLE] && !stoppedReg
                       && !(enableRise && periodReg == 16'h0000);

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      modeReg <= `RESET_BYTE;
    end else if (wrEn && wrIdx == `OFS_MODE) begin
      modeReg <= wrByte & `MODE_MASK;
    end else if (onePulseEnd) begin
      modeReg[`BIT_ENABLE] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      channelReg     <= `RESET_BYTE;
      dutyReg        <= 16'h0000;
      trailReg       <= 16'h0000;
      leadReg        <= `RESET_BYTE;
      globalIrqEnReg <= 1'b0;
      ovfIrqEnReg    <= 1'b0;
    end else if (wrEn) begin
      unique case (wrIdx)
        `OFS_CHANNEL:    channelReg <= wrByte & `CHANNEL_MASK;
        `OFS_DUTY_LO:    dutyReg[7:0] <= wrByte;
        `OFS_DUTY_HI:    dutyReg[15:8] <= wrByte;
        `OFS_TRAIL_LO:   trailReg[7:0] <= wrByte;
        `OFS_TRAIL_HI:   trailReg[15:8] <= wrByte;
        `OFS_LEAD:       leadReg <= wrByte;
        `OFS_MASTER_IRQ: globalIrqEnReg <= wrByte[`BIT_GLOBAL_IRQ];
        `OFS_IRQ4:       ovfIrqEnReg <= wrByte[`BIT_OVF_IRQ_EN];
        default: begin
        end
      endcase
    end
  end

  // a zero period seen at enable locks the period until reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      periodReg  <= 16'h0000;
      stoppedReg <= 1'b0;
    end else begin
      if (enableRise && periodReg == 16'h0000) begin
        stoppedReg <= 1'b1;
      end
      if (wrEn && !stoppedReg && wrIdx == `OFS_PERIOD_LO) begin
        periodReg[7:0] <= wrByte;
      end
      if (wrEn && !stoppedReg && wrIdx == `OFS_PERIOD_HI) begin
        periodReg[15:8] <= wrByte;
      end
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ovfFlagReg <= 1'b0;
    end else if (periodHit) begin
      ovfFlagReg <= 1'b1;
    end else if (wrEn && wrIdx == `OFS_IRQ4) begin
      ovfFlagReg <= wrByte[`BIT_OVF_FLAG];
    end
  end

  assign pwmIrq = ovfFlagReg && ovfIrqEnReg && globalIrqEnReg;

  // ****************************************
  // prescaler and counter
  // ****************************************
  function automatic logic [6:0] prescLoad(input logic [2:0] sel);
    prescLoad = 7'(`PRESC_MAX >> sel);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !runReg || tick) begin
      prescReg <= prescLoad(modeReg[`BIT_PRESC_HI:`BIT_PRESC_LO]);
    end else begin
      prescReg <= prescReg - 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enablePrevReg <= 1'b0;
      runReg        <= 1'b0;
      countReg      <= 16'h0000;
    end else begin
      enablePrevReg <= modeReg[`BIT_ENABLE];
      runReg        <= runNext;
      if (!runReg || periodHit) begin
        countReg <= 16'h0000;
      end else if (tick) begin
        countReg <= countReg + 16'h0001;
      end
    end
  end

  assign adcStart = enableRise;

  // ****************************************
  // waveform and pins
  // ****************************************
  logic waveHigh;
  logic [3:0] invVec;
  always_comb begin
    // high from zero until duty match, minus both dead bands
    waveHigh = (countReg < dutyReg)
               && (countReg >= {8'h00, leadReg})
               && (countReg < (dutyReg - trailReg))
               && ({8'h00, leadReg} < (dutyReg - trailReg))
               && (trailReg <= dutyReg);
  end
  assign invVec = {{2{modeReg[`BIT_INV2]}}, {2{modeReg[`BIT_INV1]}}};

  logic [3:0] selVec;
  assign selVec = {channelReg[5:4], channelReg[1:0]};

  // selection changes only at cycle start so no runt pulse reaches the pin
  logic cycleStart;
  // pins switch together with the first count, so the first pulse is not cut short
  assign cycleStart = !runReg || periodHit;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          pinSelReg[gi] <= 1'b0;
          pinOutReg[gi] <= 1'b0;
        end else begin
          if (cycleStart) begin
            pinSelReg[gi] <= selVec[gi] && runNext && !onePulseEnd;
          end
          pinOutReg[gi] <= (pinSelReg[gi] ? waveHigh : 1'b0) ^ invVec[gi];
        end
      end
      assign pinDrive.pinOut[gi] = pinSelReg[gi] ? pinOutReg[gi] : gpioOut[gi];
      assign pinDrive.pinSel[gi] = pinSelReg[gi];
    end
  endgenerate

  // ****************************************
  // axi read channel
  // ****************************************
  logic [7:0] rdIdx;
  logic [7:0] rdByte;
  assign rdIdx = regIndex(s_axi_araddr);
  always_comb begin
    unique case (rdIdx)
      `OFS_MODE:       rdByte = modeReg;
      `OFS_CHANNEL:    rdByte = channelReg;
      `OFS_PERIOD_LO:  rdByte = periodReg[7:0];
      `OFS_PERIOD_HI:  rdByte = periodReg[15:8];
      `OFS_DUTY_LO:    rdByte = dutyReg[7:0];
      `OFS_DUTY_HI:    rdByte = dutyReg[15:8];
      `OFS_TRAIL_LO:   rdByte = trailReg[7:0];
      `OFS_TRAIL_HI:   rdByte = trailReg[15:8];
      `OFS_LEAD:       rdByte = leadReg;
      `OFS_MASTER_IRQ: rdByte = {globalIrqEnReg, 7'h00};
      `OFS_IRQ4:       rdByte = {ovfIrqEnReg, 3'h0, ovfFlagReg, 3'h0};
      default:         rdByte = 8'h00;
    endcase
  end

  assign s_axi_arready = !rValidReg;
  assign s_axi_rvalid  = rValidReg;
  assign s_axi_rdata   = rDataReg;
  assign s_axi_rresp   = rRespReg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rValidReg <= 1'b0;
      rDataReg  <= 32'h0000_0000;
      rRespReg  <= `AXI_OKAY;
    end else if (s_axi_arvalid && !rValidReg) begin
      rValidReg <= 1'b1;
      rDataReg  <= {24'h00_0000, rdByte};
      rRespReg  <= isMapped(rdIdx) ? `AXI_OKAY : `AXI_DECERR;
    end else if (rValidReg && s_axi_rready) begin
      rValidReg <= 1'b0;
    end
  end

endmodule // pwm_timer

/* bench/pwm_load_model.sv */
// load model measuring pulse and period lengths on each pin
`timescale 1ns/1ps
module pwm_load_model (
  input  wire logic [3:0]  pinLevel,
  input  wire logic        clk_sys,
  output logic      [15:0] hiLen [4],
  output logic      [15:0] perLen [4],
  output logic      [15:0] rises [4]
);
  logic [15:0] hiCnt [4];
  logic [15:0] perCnt [4];
  logic [3:0]  last = 4'h0;
  initial foreach (hiCnt[i]) {hiLen[i], perLen[i], rises[i], hiCnt[i], perCnt[i]} = '0;
  // a load sees levels only, so lengths are whole clock cycles
  always @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      hiCnt[i] <= pinLevel[i] ? hiCnt[i] + 16'h1 : 16'h0;
      perCnt[i] <= perCnt[i] + 16'h1;
      if (pinLevel[i] && !last[i]) begin
        rises[i] <= rises[i] + 16'h1;
        perLen[i] <= perCnt[i];
        perCnt[i] <= 16'h1;
      end
      if (!pinLevel[i] && last[i]) hiLen[i] <= hiCnt[i];
    end
    last <= pinLevel;
  end
endmodule // pwm_load_model

/* bench/pwm_timer_assertions.sv */
// port checks of the pwm timer
`timescale 1ns/1ps
module pwm_timer_assertions (
  input wire logic                      clk_sys,
  input wire logic                      sys_rst,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic [3:0]                gpioOut,
  input wire pwm_timer_pkg::pin_drive_t pinDrive,
  input wire logic                      pwmIrq,
  input wire logic                      adcStart
);
  import pwm_timer_pkg::*;
  logic [3:0] wHist;
  // only a register write may start the adc or drop the request
  always_ff @(posedge clk_sys) begin
    if (sys_rst) wHist <= 4'h0;
    else wHist <= {wHist[2:0], s_axi_wvalid};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_GPIO_PASS: assert property ((pinDrive.pinOut & ~pinDrive.pinSel) == (gpioOut & ~pinDrive.pinSel))
    else $error("unselected pin not gpio");
  AST_RST_QUIET: assert property (disable iff (1'h0) sys_rst |=> !pinDrive.pinSel && !pwmIrq && !adcStart)
    else $error("outputs active after reset");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_IRQ_DROP: assert property ($fell(pwmIrq) |-> |wHist)
    else $error("request dropped without write");
  AST_ADC_PULSE: assert property (adcStart |=> !adcStart)
    else $error("adc start longer than one cycle");
  AST_ADC_CAUSE: assert property ($rose(adcStart) |-> |wHist)
    else $error("adc start without write");
endmodule // pwm_timer_assertions
bind pwm_timer pwm_timer_assertions pwm_timer_assertions_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .gpioOut(gpioOut), .pinDrive(pinDrive), .pwmIrq(pwmIrq),
  .adcStart(adcStart));

/* bench/tb_top.sv */
// self-checking bench of the pwm timer
`timescale 1ns/1ps
`include "pwm_timer_defs.svh"
module tb_top;
  import pwm_timer_pkg::*;
  logic        clk_sys = 1'h0;
  logic        sys_rst = 1'h1;
  logic [9:0]  awAddr = 10'h000, arAddr = 10'h000;
  logic [31:0] wData = 32'h0, rData;
  logic [3:0]  gpioOut = 4'h0;
  logic        awValid = 1'h0, wValid = 1'h0, arValid = 1'h0;
  logic        awReady, wReady, bValid, arReady, rValid, pwmIrq, adcStart;
  logic [1:0]  bResp, rResp;
  pin_drive_t  pinDrive;
  logic [15:0] hiLen [4], perLen [4], rises [4], r0;
  int          nMismatch = 0, numChecks = 0, adcCnt = 0, enCnt = 0;
  logic [7:0]  ofs [11] = '{`OFS_MASTER_IRQ, `OFS_MODE, `OFS_PERIOD_LO, `OFS_PERIOD_HI,
    `OFS_TRAIL_LO, `OFS_TRAIL_HI, `OFS_DUTY_LO, `OFS_DUTY_HI, `OFS_LEAD, `OFS_CHANNEL, `OFS_IRQ4};
  logic [7:0]  pat [11] = '{8'hFF, 8'h7E, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h08};
  logic [7:0]  msk [11] = '{8'h80, 8'hFD, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h33, 8'h88};
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (adcStart === 1'h1) adcCnt++;
  pwm_timer pwm_timer_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'h1),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'h1),
    .gpioOut(gpioOut), .pinDrive(pinDrive), .pwmIrq(pwmIrq), .adcStart(adcStart));
  pwm_load_model pwm_load_model_i (.pinLevel(pinDrive.pinOut), .clk_sys(clk_sys),
    .hiLen(hiLen), .perLen(perLen), .rises(rises));
  // ****************
  // tasks
  // ****************
  task automatic test_done;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ready and valid are sampled at the falling edge, away from the updates
  task automatic wrReg(input logic [7:0] a, d, input logic [1:0] er = 2'h0);
    int n;
    logic aw, w, b;
    logic [1:0] rsp;
    n = 0;
    b = 1'h0;
    awAddr <= {a, 2'h0};
    awValid <= 1'h1;
    wData <= {24'h0, d};
    wValid <= 1'h1;
    while (!b && n < 300) begin
      @(negedge clk_sys);
      aw = awReady & awValid;
      w = wReady & wValid;
      b = bValid;
      rsp = bResp;
      @(posedge clk_sys);
      if (aw) awValid <= 1'h0;
      if (w) wValid <= 1'h0;
      n++;
    end
    if (!b) begin
      nMismatch++;
      test_done();
    end
    check("bresp", rsp, er);
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp,
                       input logic [1:0] er = 2'h0);
    int n;
    logic ar, v;
    logic [31:0] d;
    logic [1:0] rsp;
    n = 0;
    v = 1'h0;
    arAddr <= {a, 2'h0};
    arValid <= 1'h1;
    while (!v && n < 300) begin
      @(negedge clk_sys);
      ar = arReady & arValid;
      v = rValid;
      d = rData;
      rsp = rResp;
      @(posedge clk_sys);
      if (ar) arValid <= 1'h0;
      n++;
    end
    if (!v) begin
      nMismatch++;
      test_done();
    end
    check(what, d, exp);
    check("rresp", rsp, er);
  endtask
  task automatic runPwm(input logic [2:0] sel, input logic [3:0] low, input int per, duty);
    wrReg(`OFS_MODE, 8'h00);
    wrReg(`OFS_PERIOD_LO, per[7:0]);
    wrReg(`OFS_PERIOD_HI, 8'h00);
    wrReg(`OFS_DUTY_LO, duty[7:0]);
    wrReg(`OFS_MODE, {1'h1, sel, low});
    enCnt++;
    repeat ((per + 1) * (128 >> sel) * 3 + 40) @(posedge clk_sys);
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'h0;
    for (int i = 0; i < 11; i++) rdChk("reset", ofs[i], 32'h0);
    for (int i = 0; i < 11; i++) begin
      wrReg(ofs[i], pat[i]);
      rdChk("rw", ofs[i], {24'h0, pat[i] & msk[i]});
    end
    rdChk("unmapped", 8'h00, 32'h0, 2'h3);
    wrReg(8'h00, 8'hFF, 2'h3);
    check("masked", pwmIrq, 32'h0);
    wrReg(`OFS_IRQ4, 8'h88);
    @(negedge clk_sys);
    check("irq", pwmIrq, 32'h1);
    @(posedge clk_sys);
    wrReg(`OFS_MASTER_IRQ, 8'h00);
    @(negedge clk_sys);
    check("gated", pwmIrq, 32'h0);
    @(posedge clk_sys);
    wrReg(`OFS_MASTER_IRQ, 8'h80);
    wrReg(`OFS_IRQ4, 8'h80);
    rdChk("flag clear", `OFS_IRQ4, 32'h80);
    for (int i = 4; i < 9; i++) if (i != 6) wrReg(ofs[i], 8'h00);
    wrReg(`OFS_CHANNEL, 8'h01);
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      runPwm(s[2:0], 4'h0, 2, 1);
      check("period", perLen[0], 2 * (128 >> s));
      check("high", hiLen[0], 128 >> s);
    end
    check("adc", adcCnt, enCnt);
    rdChk("flag set", `OFS_IRQ4, 32'h88);
    $display("test prescaler done");
    wrReg(`OFS_CHANNEL, 8'h11);
    runPwm(3'h7, 4'h4, 4, 1);
    check("inv1", hiLen[0], 3);
    check("plain2", hiLen[2], 1);
    check("cycle4", perLen[2], 4);
    runPwm(3'h7, 4'h8, 4, 1);
    check("plain1", hiLen[0], 1);
    check("inv2", hiLen[2], 3);
    $display("test invert done");
    wrReg(`OFS_MODE, 8'h00);
    wrReg(`OFS_LEAD, 8'h08);
    r0 = rises[0];
    runPwm(3'h7, 4'h0, 4, 2);
    check("no pulse", rises[0], r0);
    wrReg(`OFS_MODE, 8'h00);
    wrReg(`OFS_LEAD, 8'h00);
    r0 = rises[0];
    runPwm(3'h7, 4'h1, 4, 2);
    check("one pulse", rises[0] - r0, 1);
    rdChk("self clear", `OFS_MODE, 32'h71);
    gpioOut <= 4'hA;
    @(negedge clk_sys);
    check("pins", pinDrive, {4'hA, 4'h0});
    @(posedge clk_sys);
    $display("test pulse done");
    runPwm(3'h7, 4'h0, 0, 0);
    r0 = rises[0];
    wrReg(`OFS_PERIOD_LO, 8'h04);
    repeat (100) @(posedge clk_sys);
    check("stopped", rises[0], r0);
    rdChk("period held", `OFS_PERIOD_LO, 32'h0);
    $display("test zero period done");
    test_done();
  end
endmodule // tb_top
